/* File: verilog/pmc_core.sv */
// How it works
// RULE1: seven modes; every mode but high-speed active flags power-down
// RULE2: both active modes clock cpu from system clock, medium at reduced rate
// RULE3: subactive clocks cpu from the subclock at reduced speed
// RULE4: sleep stops cpu clock, peripherals keep the system clock
// RULE5: subsleep halts cpu; interval, event timer and display run on subclock
// RULE6: watch halts cpu; timekeeping timer and display run on subclock
// RULE7: standby stops cpu and all peripherals, contents kept
// RULE8: only an accepted interrupt leaves a low-power mode
// RULE9: standby drives io to high impedance, io registers kept
// RULE10: retained interrupt input ignored in low modes, its flag untouched
// RULE11: interval timer runs in subclock modes only with timekeeping selected
// RULE12: event timer runs in subclock modes only with its slow source selected
// RULE13: display standby gates display clock and grounds display outputs
// RULE14: two control registers at fff0 and fff1, reset 07 and e0
// RULE15: deep-sleep select picks sleep/subsleep or standby/watch on sleep
// RULE16: wake from standby or watch waits selected settle count
// RULE17: leaving standby, watch or sleep resumes medium or high speed; code returns from watch to subactive when low-speed wake select is set
// RULE18: subactive cpu clock is watch clock over 8, 4 or 2, locked there
// RULE19: system oscillator off in subclock and standby modes, subclock always on
// RULE20: second serial port held reset in subclock and standby modes
`timescale 1ns/1ps
`default_nettype none
module pmc_core #(
  parameter int SETTLE_BASE = 8192
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pmc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_req,
  input wire logic int_accept,
  input wire logic ext_int_zero,
  input wire logic ext_int_one,
  input wire logic [7:0] wake_pins,
  input wire logic sub_clk,
  output logic [2:0] mode_code,
  output logic power_down,
  output logic cpu_clk_en,
  output logic sys_osc_en,
  output logic sub_osc_en,
  output logic periph_clk_en,
  output logic timer_a_clk_en,
  output logic event_timer_clk_en,
  output logic display_clk_en,
  output logic display_out_ground,
  output logic io_hiz,
  output logic serial_port_b_reset,
  output logic [pmc_pkg::FLAG_W-1:0] int_flags
);

  typedef struct packed {
    pmc_pkg::pmc_state_type st;
    logic [7:0] ctl1;
    logic [7:0] ctl2;
    logic [2:0] cfg;
    logic [pmc_pkg::FLAG_W-1:0] flags;
    logic [pmc_pkg::FLAG_W-1:0] pin_prev;
    logic sub_prev;
    logic [pmc_pkg::SETTLE_W-1:0] settle;
    logic [pmc_pkg::DIV_W-1:0] div;
    logic [31:0] rdata;
    logic rdy;
    logic err;
    logic cpu;
    logic sosc;
    logic wosc;
    logic periph;
    logic ta;
    logic tc;
    logic disp;
    logic dgnd;
    logic hiz;
    logic sbrst;
    logic pd;
    logic [2:0] code;
  } pmc_core_type;

  localparam pmc_core_type CORE_RST = '{
    st: pmc_pkg::ST_HIGH,
    ctl1: pmc_pkg::CTRL_ONE_RST,
    ctl2: pmc_pkg::CTRL_TWO_RST,
    cfg: pmc_pkg::CFG_RST,
    cpu: 1'b1,
    sosc: 1'b1,
    wosc: 1'b1,
    periph: 1'b1,
    ta: 1'b1,
    tc: 1'b1,
    disp: 1'b1,
    default: '0
  };

  pmc_core_type r;
  pmc_core_type nx;
  logic [pmc_pkg::PIN_W-1:0] pins_s;
  logic sub_tick;
  logic [pmc_pkg::FLAG_W-1:0] rise;
  logic [pmc_pkg::FLAG_W-1:0] set_v;
  logic [pmc_pkg::FLAG_W-1:0] clr_v;
  logic setup;
  logic acc;
  logic wr;
  logic ign1;
  logic act_n;
  logic sleep_n;
  logic subm_n;

  ////////////////////////////////////////////////////////////////////////////
  // helper functions

  function automatic logic hit(input logic [pmc_pkg::ADDR_W-1:0] a, input logic [15:0] idx);
    hit = (a[1:0] == 2'h0) && (a[pmc_pkg::ADDR_W-1:2] == idx);
  endfunction

  function automatic logic [pmc_pkg::SETTLE_W-1:0] settle_len(input logic [2:0] sel);
    logic [2:0] sh;
    sh = sel[2] ? 3'h4 : {1'b0, sel[1:0]};
    settle_len = pmc_pkg::SETTLE_W'(SETTLE_BASE) << sh;
  endfunction

  function automatic logic [pmc_pkg::DIV_W-1:0] sub_last(input logic [1:0] sa);
    sub_last = sa[1] ? pmc_pkg::SUB_DIV2 : (sa[0] ? pmc_pkg::SUB_DIV4 : pmc_pkg::SUB_DIV8);
  endfunction

  function automatic logic [2:0] code_of(input pmc_pkg::pmc_state_type s);
    case (s)
      pmc_pkg::ST_HIGH: code_of = pmc_pkg::CODE_HIGH;
      pmc_pkg::ST_MED: code_of = pmc_pkg::CODE_MED;
      pmc_pkg::ST_SUB: code_of = pmc_pkg::CODE_SUB;
      pmc_pkg::ST_SLEEP: code_of = pmc_pkg::CODE_SLEEP;
      pmc_pkg::ST_SUBSLEEP: code_of = pmc_pkg::CODE_SUBSLEEP;
      pmc_pkg::ST_WATCH: code_of = pmc_pkg::CODE_WATCH;
      pmc_pkg::ST_STANDBY: code_of = pmc_pkg::CODE_STANDBY;
      default: code_of = pmc_pkg::CODE_SETTLE;
    endcase
  endfunction

  function automatic logic is_subm(input pmc_pkg::pmc_state_type s);
    is_subm = (s == pmc_pkg::ST_WATCH) || (s == pmc_pkg::ST_SUB) ||
              (s == pmc_pkg::ST_SUBSLEEP) || (s == pmc_pkg::ST_STANDBY);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: interrupt pins, wake pins and subclock

  pmc_sync #(.W(pmc_pkg::PIN_W)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .d({sub_clk, ext_int_one, ext_int_zero, wake_pins}),
    .q(pins_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    nx = r;
    // subclock edge and pin edges
    sub_tick = pins_s[10] & ~r.sub_prev;
    nx.sub_prev = pins_s[10];
    rise = pins_s[9:0] & ~r.pin_prev;
    nx.pin_prev = pins_s[9:0];
    ign1 = is_subm(r.st); // [RULE10]
    set_v = {rise[9] & ~ign1, rise[8:0]}; // [RULE10]

    // apb: answer prepared in setup, taken in access
    setup = psel & ~penable;
    acc = psel & penable & r.rdy;
    wr = acc & pwrite & ~r.err;
    nx.rdy = setup;
    nx.err = 1'b0; // error flag stands only with pready
    if (setup) begin
      nx.rdata = 32'h0;
      if (hit(paddr, pmc_pkg::IDX_CTRL_ONE)) begin
        nx.rdata = {24'h0, r.ctl1};
      end else if (hit(paddr, pmc_pkg::IDX_CTRL_TWO)) begin
        nx.rdata = {24'h0, r.ctl2};
      end else if (hit(paddr, pmc_pkg::IDX_CFG)) begin
        nx.rdata = {29'h0, r.cfg};
      end else if (hit(paddr, pmc_pkg::IDX_STAT)) begin
        nx.rdata = {14'h0, r.flags, 5'h0, r.code};
      end else begin
        nx.err = 1'b1;
      end
    end

    // register writes, reserved bits stay at one
    if (wr && hit(paddr, pmc_pkg::IDX_CTRL_ONE)) begin
      nx.ctl1 = (pwdata[7:0] & pmc_pkg::CTRL_ONE_WMASK) | pmc_pkg::CTRL_ONE_RST; // [RULE14]
    end
    if (wr && hit(paddr, pmc_pkg::IDX_CTRL_TWO)) begin
      nx.ctl2 = (pwdata[7:0] & pmc_pkg::CTRL_TWO_WMASK) | pmc_pkg::CTRL_TWO_RST; // [RULE14]
      if (r.st == pmc_pkg::ST_SUB) begin
        nx.ctl2 = (nx.ctl2 & ~pmc_pkg::CTRL_TWO_DIVMASK) | (r.ctl2 & pmc_pkg::CTRL_TWO_DIVMASK); // [RULE18]
      end
    end
    if (wr && hit(paddr, pmc_pkg::IDX_CFG)) begin
      nx.cfg = pwdata[2:0];
    end
    // flags: write one clears, a new edge wins
    clr_v = (wr && hit(paddr, pmc_pkg::IDX_STAT)) ?
            pwdata[pmc_pkg::STAT_FLAG_LO +: pmc_pkg::FLAG_W] : '0;
    nx.flags = (r.flags & ~clr_v) | set_v;

    // mode sequencer
    case (r.st)
      pmc_pkg::ST_HIGH, pmc_pkg::ST_MED: begin
        if (sleep_req) begin
          if (!r.ctl1[pmc_pkg::C1_DEEP]) begin
            nx.st = pmc_pkg::ST_SLEEP; // [RULE15]
          end else if (r.cfg[pmc_pkg::CFG_TB]) begin
            nx.st = pmc_pkg::ST_WATCH; // [RULE15]
          end else begin
            nx.st = pmc_pkg::ST_STANDBY; // [RULE15]
          end
        end
      end
      pmc_pkg::ST_SUB: begin
        if (sleep_req) begin
          nx.st = r.ctl1[pmc_pkg::C1_DEEP] ? pmc_pkg::ST_WATCH : pmc_pkg::ST_SUBSLEEP; // [RULE15]
        end
      end
      pmc_pkg::ST_SLEEP: begin
        if (int_accept) begin
          nx.st = r.ctl2[pmc_pkg::C2_MED] ? pmc_pkg::ST_MED : pmc_pkg::ST_HIGH; // [RULE8] [RULE17]
        end
      end
      pmc_pkg::ST_SUBSLEEP: begin
        if (int_accept) begin
          nx.st = pmc_pkg::ST_SUB; // [RULE8]
        end
      end
      pmc_pkg::ST_WATCH: begin
        if (int_accept) begin
          nx.st = r.ctl1[pmc_pkg::C1_LOW_SPEED_WAKE_SELECT] ? pmc_pkg::ST_SUB : pmc_pkg::ST_SETTLE; // [RULE8]
        end
      end
      pmc_pkg::ST_STANDBY: begin
        if (int_accept) begin
          nx.st = pmc_pkg::ST_SETTLE; // [RULE8]
        end
      end
      pmc_pkg::ST_SETTLE: begin
        if (r.settle == '0) begin
          nx.st = r.ctl2[pmc_pkg::C2_MED] ? pmc_pkg::ST_MED : pmc_pkg::ST_HIGH; // [RULE17]
        end else begin
          nx.settle = r.settle - 1'b1; // [RULE16]
        end
      end
      default: begin
        nx.st = pmc_pkg::ST_HIGH;
      end
    endcase
    if (nx.st == pmc_pkg::ST_SETTLE && r.st != pmc_pkg::ST_SETTLE) begin
      nx.settle = settle_len(r.ctl1[6:pmc_pkg::C1_WAIT_LO]) - 1'b1; // [RULE16]
    end

    // cpu clock divider: system cycles in medium, subclock ticks in subactive
    nx.cpu = 1'b0;
    if (nx.st != r.st) begin
      nx.div = '0;
    end else if (r.st == pmc_pkg::ST_MED) begin
      nx.div = r.div + 1'b1;
      nx.cpu = (r.div == pmc_pkg::MED_DIV); // [RULE2]
    end else if (r.st == pmc_pkg::ST_SUB && sub_tick) begin
      nx.cpu = (r.div >= sub_last(r.ctl2[1:0])); // [RULE3] [RULE18]
      nx.div = nx.cpu ? '0 : r.div + 1'b1;
    end
    if (nx.st == pmc_pkg::ST_HIGH) begin
      nx.cpu = 1'b1; // [RULE2]
    end

    // per-mode gating, decoded from the mode being entered
    act_n = (nx.st == pmc_pkg::ST_HIGH) || (nx.st == pmc_pkg::ST_MED);
    sleep_n = act_n || (nx.st == pmc_pkg::ST_SLEEP);
    subm_n = (nx.st == pmc_pkg::ST_WATCH) || (nx.st == pmc_pkg::ST_SUB) ||
             (nx.st == pmc_pkg::ST_SUBSLEEP);
    nx.periph = sleep_n; // [RULE4] [RULE7]
    nx.sosc = sleep_n || (nx.st == pmc_pkg::ST_SETTLE); // [RULE19]
    nx.wosc = 1'b1; // [RULE19]
    nx.ta = sleep_n || (subm_n && nx.cfg[pmc_pkg::CFG_TB]); // [RULE5] [RULE6] [RULE11]
    nx.tc = sleep_n || (nx.st == pmc_pkg::ST_SUB || nx.st == pmc_pkg::ST_SUBSLEEP) &&
            nx.cfg[pmc_pkg::CFG_EVT]; // [RULE5] [RULE12]
    nx.disp = ~nx.cfg[pmc_pkg::CFG_DSTBY] && (nx.st != pmc_pkg::ST_STANDBY); // [RULE6] [RULE7] [RULE13]
    nx.dgnd = nx.cfg[pmc_pkg::CFG_DSTBY]; // [RULE13]
    nx.hiz = (nx.st == pmc_pkg::ST_STANDBY); // [RULE9]
    nx.sbrst = is_subm(nx.st); // [RULE20]
    nx.pd = (nx.st != pmc_pkg::ST_HIGH); // [RULE1]
    nx.code = code_of(nx.st); // [RULE1]
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= CORE_RST; // [RULE14]
    end else if (ce) begin
      r <= nx;
    end
  end

  // outputs straight from the state register
  assign prdata = r.rdata;
  assign pready = r.rdy;
  assign pslverr = r.err;
  assign mode_code = r.code;
  assign power_down = r.pd;
  assign cpu_clk_en = r.cpu;
  assign sys_osc_en = r.sosc;
  assign sub_osc_en = r.wosc;
  assign periph_clk_en = r.periph;
  assign timer_a_clk_en = r.ta;
  assign event_timer_clk_en = r.tc;
  assign display_clk_en = r.disp;
  assign display_out_ground = r.dgnd;
  assign io_hiz = r.hiz;
  assign serial_port_b_reset = r.sbrst;
  assign int_flags = r.flags;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_wake_deep;
    ce && int_accept && (r.st == pmc_pkg::ST_STANDBY);
  endsequence
  sequence s_settle_loaded;
    (r.st == pmc_pkg::ST_SETTLE) && (r.settle == settle_len(r.ctl1[6:4]) - 1'b1);
  endsequence

  a_power_down_flag: assert property (power_down == (r.st != pmc_pkg::ST_HIGH)) // [RULE1]
    else $error("power-down flag disagrees with mode");
  a_high_cpu_clock: assert property ((r.st == pmc_pkg::ST_HIGH) |-> cpu_clk_en && sys_osc_en) // [RULE2]
    else $error("high-speed mode without cpu clock");
  a_sub_cpu_tick: assert property (ce && (r.st == pmc_pkg::ST_SUB) && !sub_tick && // [RULE3]
    (nx.st == pmc_pkg::ST_SUB) |=> !cpu_clk_en)
    else $error("subactive cpu clock without subclock tick");
  a_sleep_gating: assert property ((r.st == pmc_pkg::ST_SLEEP) |-> !cpu_clk_en && periph_clk_en) // [RULE4]
    else $error("sleep gating wrong");
  a_subsleep_gating: assert property ((r.st == pmc_pkg::ST_SUBSLEEP) |-> // [RULE5]
    !cpu_clk_en && !periph_clk_en && display_clk_en == !r.cfg[pmc_pkg::CFG_DSTBY])
    else $error("subsleep gating wrong");
  a_watch_timer: assert property ((r.st == pmc_pkg::ST_WATCH) |-> // [RULE6]
    !cpu_clk_en && !event_timer_clk_en && timer_a_clk_en == r.cfg[pmc_pkg::CFG_TB])
    else $error("watch gating wrong");
  a_standby_stop: assert property ((r.st == pmc_pkg::ST_STANDBY) |-> io_hiz && !periph_clk_en && // [RULE7]
    !timer_a_clk_en && !display_clk_en && !cpu_clk_en)
    else $error("standby gating wrong");
  a_wake_needs_accept: assert property ((r.st inside {pmc_pkg::ST_SLEEP, pmc_pkg::ST_SUBSLEEP, // [RULE8]
    pmc_pkg::ST_WATCH, pmc_pkg::ST_STANDBY}) && !int_accept |=> $stable(r.st))
    else $error("low-power mode left without accepted interrupt");
  a_int1_ignored: assert property (ce && is_subm(r.st) && !$past(int_flags[pmc_pkg::FLAG_INT1]) && // [RULE10]
    !int_flags[pmc_pkg::FLAG_INT1] |=> !int_flags[pmc_pkg::FLAG_INT1])
    else $error("retained interrupt flag set in low mode");
  a_event_timer: assert property ((r.st inside {pmc_pkg::ST_SUB, pmc_pkg::ST_SUBSLEEP}) |-> // [RULE12]
    event_timer_clk_en == r.cfg[pmc_pkg::CFG_EVT])
    else $error("event timer gating wrong");
  a_display_standby: assert property (r.cfg[pmc_pkg::CFG_DSTBY] |-> !display_clk_en && display_out_ground) // [RULE13]
    else $error("display standby not applied");
  a_deep_select: assert property (ce && sleep_req && (r.st == pmc_pkg::ST_HIGH) && // [RULE15]
    !r.ctl1[pmc_pkg::C1_DEEP] |=> r.st == pmc_pkg::ST_SLEEP)
    else $error("sleep request did not enter sleep");
  a_settle_load: assert property (s_wake_deep |=> s_settle_loaded) // [RULE16]
    else $error("settle count not loaded on wake");
  a_settle_end: assert property (ce && (r.st == pmc_pkg::ST_SETTLE) && (r.settle == '0) |=> // [RULE17]
    r.st == ($past(r.ctl2[pmc_pkg::C2_MED]) ? pmc_pkg::ST_MED : pmc_pkg::ST_HIGH))
    else $error("settle did not resume in selected speed");
  a_div_locked: assert property ((r.st == pmc_pkg::ST_SUB) |=> $stable(r.ctl2[1:0])) // [RULE18]
    else $error("subactive divider changed in subactive");
  a_low_osc_serial: assert property (is_subm(r.st) |-> serial_port_b_reset && !sys_osc_en && // [RULE19]
    sub_osc_en)
    else $error("oscillator or serial reset wrong in low mode");

endmodule
`default_nettype wire

/* File: common/pmc_pkg.sv */
package pmc_pkg;

  // apb address width, registers sit at four times their index
  localparam int ADDR_W = 18;
  localparam logic [15:0] IDX_CTRL_ONE = 16'hfff0;
  localparam logic [15:0] IDX_CTRL_TWO = 16'hfff1;
  localparam logic [15:0] IDX_CFG = 16'hfff2;
  localparam logic [15:0] IDX_STAT = 16'hfff3;

  // power_control_one layout
  localparam logic [7:0] CTRL_ONE_RST = 8'h07;
  localparam logic [7:0] CTRL_ONE_WMASK = 8'hf8;
  localparam int C1_DEEP = 7;
  localparam int C1_WAIT_LO = 4;
  localparam int C1_LOW_SPEED_WAKE_SELECT = 3;

  // power_control_two layout
  localparam logic [7:0] CTRL_TWO_RST = 8'he0;
  localparam logic [7:0] CTRL_TWO_WMASK = 8'h1f;
  localparam logic [7:0] CTRL_TWO_DIVMASK = 8'h03;
  localparam int C2_MED = 2;

  // own configuration register
  localparam logic [2:0] CFG_RST = 3'h0;
  localparam int CFG_TB = 0;
  localparam int CFG_EVT = 1;
  localparam int CFG_DSTBY = 2;

  // status register: mode code low, flags from bit 8
  localparam int STAT_FLAG_LO = 8;
  localparam int FLAG_W = 10;
  localparam int FLAG_INT0 = 8;
  localparam int FLAG_INT1 = 9;
  localparam int PIN_W = 11;

  // settle counter and clock dividers
  localparam int SETTLE_W = 18;
  localparam int DIV_W = 4;
  localparam logic [3:0] MED_DIV = 4'hf;
  localparam logic [3:0] SUB_DIV8 = 4'h7;
  localparam logic [3:0] SUB_DIV4 = 4'h3;
  localparam logic [3:0] SUB_DIV2 = 4'h1;

  // mode codes as read back
  localparam logic [2:0] CODE_HIGH = 3'h0;
  localparam logic [2:0] CODE_MED = 3'h1;
  localparam logic [2:0] CODE_SUB = 3'h2;
  localparam logic [2:0] CODE_SLEEP = 3'h3;
  localparam logic [2:0] CODE_SUBSLEEP = 3'h4;
  localparam logic [2:0] CODE_WATCH = 3'h5;
  localparam logic [2:0] CODE_STANDBY = 3'h6;
  localparam logic [2:0] CODE_SETTLE = 3'h7;

  typedef enum logic [7:0] {
    ST_HIGH = 8'h01,
    ST_MED = 8'h02,
    ST_SUB = 8'h04,
    ST_SLEEP = 8'h08,
    ST_SUBSLEEP = 8'h10,
    ST_WATCH = 8'h20,
    ST_STANDBY = 8'h40,
    ST_SETTLE = 8'h80
  } pmc_state_type;

endpackage

/* File: verilog/pmc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pmc_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pmc_sync_type;

  pmc_sync_type st_reg;
  pmc_sync_type st_next;

  // two-stage chain, first stage feeds only the second
  always_comb begin
    st_next = st_reg;
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.s2;

endmodule
`default_nettype wire

/* File: bench/pmc_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pmc_cpu_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go_sleep,
  input wire logic go_wake,
  input wire logic pending,
  input wire logic [3:0] lag,
  output logic sleep_req,
  output logic int_accept
);
  logic [3:0] cnt;
  logic busy;
  logic kind;
  // command delayed by lag cycles, then a one-cycle request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
      busy <= 1'b0;
      kind <= 1'b0;
      sleep_req <= 1'b0;
      int_accept <= 1'b0;
    end else begin
      sleep_req <= 1'b0;
      int_accept <= 1'b0;
      if (busy) begin
        if (cnt == 4'h0) begin
          busy <= 1'b0;
          int_accept <= kind & pending; // accept only a raised request
          sleep_req <= ~kind;
        end else begin
          cnt <= cnt - 4'h1;
        end
      end else if (go_sleep | go_wake) begin
        busy <= 1'b1;
        kind <= go_wake;
        cnt <= lag;
      end
    end
  end
endmodule
`default_nettype wire

/* File: bench/pmc_core_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module pmc_core_bench;
  localparam int BASE = 4;
  localparam logic [17:0] A1 = 18'h3ffc0;
  localparam logic [17:0] A2 = 18'h3ffc4;
  localparam logic [17:0] AC = 18'h3ffc8;
  localparam logic [17:0] AS = 18'h3ffcc;
  logic pclk = 1'b0;
  logic sub_clk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0;
  logic [9:0] pins = 10'h0;
  logic go_sleep = 1'b0;
  logic go_wake = 1'b0;
  logic [3:0] lag = 4'h0;
  logic [31:0] prdata;
  logic pready, pslverr, sleep_req, int_accept;
  logic [2:0] mode_code;
  logic power_down, cpu_clk_en, sys_osc_en, sub_osc_en, periph_clk_en, timer_a_clk_en;
  logic event_timer_clk_en, display_clk_en, display_out_ground, io_hiz, serial_port_b_reset;
  logic [9:0] int_flags;
  logic [10:0] gates;
  logic [31:0] rd;
  logic err;
  int n_fail = 0;
  int num_checks = 0;
  int n;
  ////////////////////////////////////////////////////////////////
  always #12.5 pclk = ~pclk;
  always #200 sub_clk = ~sub_clk;
  // all gate outputs in one vector
  assign gates = {power_down, cpu_clk_en, sys_osc_en, sub_osc_en, periph_clk_en, timer_a_clk_en,
    event_timer_clk_en, display_clk_en, display_out_ground, io_hiz, serial_port_b_reset};
  pmc_core #(.SETTLE_BASE(BASE)) u_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep_req(sleep_req), .int_accept(int_accept),
    .ext_int_zero(pins[8]), .ext_int_one(pins[9]), .wake_pins(pins[7:0]), .sub_clk(sub_clk),
    .mode_code(mode_code), .power_down(power_down), .cpu_clk_en(cpu_clk_en),
    .sys_osc_en(sys_osc_en), .sub_osc_en(sub_osc_en), .periph_clk_en(periph_clk_en),
    .timer_a_clk_en(timer_a_clk_en), .event_timer_clk_en(event_timer_clk_en),
    .display_clk_en(display_clk_en), .display_out_ground(display_out_ground), .io_hiz(io_hiz),
    .serial_port_b_reset(serial_port_b_reset), .int_flags(int_flags));
  pmc_cpu_model u_cpu (.pclk(pclk), .presetn(presetn), .go_sleep(go_sleep), .go_wake(go_wake),
    .pending(|int_flags), .lag(lag), .sleep_req(sleep_req), .int_accept(int_accept));
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [17:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  task automatic cpu(input logic wake);
    @(posedge pclk);
    go_wake <= wake;
    go_sleep <= ~wake;
    @(posedge pclk);
    go_wake <= 1'b0;
    go_sleep <= 1'b0;
  endtask
  task automatic wait_mode(input logic [2:0] m);
    int k;
    k = 0;
    while (mode_code !== m && k < 300) begin
      @(posedge pclk);
      k++;
    end
    check({29'h0, mode_code}, {29'h0, m});
  endtask
  // pin edge, held long enough for the synchronisers
  task automatic poke(input logic [9:0] v);
    pins <= v;
    repeat (4) @(posedge pclk);
    pins <= 10'h0;
    repeat (4) @(posedge pclk);
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // hang guard
  initial begin
    repeat (30000) @(posedge pclk);
    n_fail++;
    finish_test();
  end
  // main sequence
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check({21'h0, gates}, 32'h3f8);
    rd_chk(A1, 32'h07);
    rd_chk(A2, 32'he0);
    rd_chk(AS, 32'h0);
    apb(1'b1, A1, 32'hff);
    rd_chk(A1, 32'hff);
    apb(1'b1, A1, 32'h00);
    rd_chk(A1, 32'h07);
    apb(1'b0, 18'h3ffd0, 32'h0);
    check({31'h0, err}, 32'h1);
    $display("test registers done");
    cpu(1'b0);
    wait_mode(3'h3);
    check({21'h0, gates}, 32'h5f8);
    poke(10'h001);
    check({22'h0, int_flags}, 32'h001);
    check({29'h0, mode_code}, 32'h3);
    apb(1'b1, A2, 32'h04);
    lag <= 4'h9;
    cpu(1'b1);
    wait_mode(3'h1);
    n = 0;
    repeat (64) begin
      @(posedge pclk);
      if (cpu_clk_en === 1'b1)
        n++;
    end
    check(32'(n), 32'h4);
    apb(1'b1, AS, 32'h3ff00);
    apb(1'b1, A2, 32'h00);
    $display("test sleep done");
    // standby wake for settle codes 0 to 5
    for (int s = 0; s < 6; s++) begin
      apb(1'b1, A1, {24'h0, 1'b1, 3'(s), 4'h0});
      cpu(1'b0);
      wait_mode(3'h6);
      check({21'h0, gates}, 32'h483);
      poke(10'h100);
      cpu(1'b1);
      wait_mode(3'h7);
      n = 0;
      while (mode_code === 3'h7 && n < 300) begin
        @(posedge pclk);
        n++;
      end
      check(32'(n), 32'(BASE << ((s > 4) ? 4 : s)));
      wait_mode(3'h0);
      apb(1'b1, AS, 32'h3ff00);
    end
    $display("test standby done");
    apb(1'b1, AC, 32'h3);
    apb(1'b1, A1, 32'h88);
    cpu(1'b0);
    wait_mode(3'h5);
    check({21'h0, gates}, 32'h4a9);
    poke(10'h008);
    cpu(1'b1);
    wait_mode(3'h2);
    apb(1'b1, AS, 32'h3ff00);
    apb(1'b1, A2, 32'h03);
    rd_chk(A2, 32'he0);
    check({27'h0, sys_osc_en, periph_clk_en, timer_a_clk_en, event_timer_clk_en,
      serial_port_b_reset}, 32'h7);
    // subclock tick every 16 cycles, cpu pulse every 8 ticks
    n = 0;
    repeat (256) begin
      @(posedge pclk);
      if (cpu_clk_en === 1'b1)
        n++;
    end
    check(32'(n), 32'h2);
    poke(10'h300);
    rd_chk(AS, 32'h10002);
    apb(1'b1, AS, 32'h3ff00);
    rd_chk(AS, 32'h2);
    $display("test subactive done");
    apb(1'b1, A1, 32'h08);
    apb(1'b1, AC, 32'h1);
    cpu(1'b0);
    wait_mode(3'h4);
    check({21'h0, gates}, 32'h4a9);
    poke(10'h002);
    cpu(1'b1);
    wait_mode(3'h2);
    apb(1'b1, AS, 32'h3ff00);
    apb(1'b1, A1, 32'h80);
    cpu(1'b0);
    wait_mode(3'h5);
    poke(10'h004);
    cpu(1'b1);
    wait_mode(3'h0);
    apb(1'b1, AC, 32'h4);
    repeat (2) @(posedge pclk);
    check({30'h0, display_clk_en, display_out_ground}, 32'h1);
    $display("test subsleep and display done");
    finish_test();
  end
endmodule
`default_nettype wire
